// ===== vta_regs.svh
// Register offsets, field positions, reset values and timing counts of the alarm controller
// ----------------------------------------------------------------------------
// What this block does
// - Refuse arming under accessory or ignition power
// - Arm on battery feed only; unlock disarms under any power state
// - Lock from barrel, remote or handle arms
// - Enable siren and tilt unit first
// - Then check door, hood, trunk contacts
// - Link settled contacts into monitoring
// - Double-lock initializes tilt and motion detector
// - Tilt monitored only with plausible rest value
// - Motion detector active 30 s after linking
// - Second double lock within 10 s disables tilt, motion
// - Disable acknowledged by LED for 2 s
// - Armed door contact change raises alarm
// - Armed hood change raises alarm
// - Armed trunk change raises alarm
// - Armed siren tamper raises alarm
// - Alarm both audible and visual
// - Unlock disarms
// ----------------------------------------------------------------------------
`ifndef VTA_REGS_SVH
`define VTA_REGS_SVH
`define VTA_CLK_HZ 50000000
`define VTA_TICK_HZ 1
`define VTA_TICK_DIV (`VTA_CLK_HZ / `VTA_TICK_HZ)
`define VTA_MOTION_DELAY_S 30
`define VTA_RELOCK_WINDOW_S 10
`define VTA_ACK_LED_S 2
`define VTA_ADDR_CTRL 4'h0
`define VTA_ADDR_STATUS 4'h4
`define VTA_ADDR_IRQ_STAT 4'h8
`define VTA_ADDR_IRQ_MASK 4'hC
`define VTA_CTRL_ENABLE 0
`define VTA_CTRL_RESET 32'h00000001
`define VTA_MASK_RESET 32'h00000000
`define VTA_IRQ_ARMED 0
`define VTA_IRQ_ALARM 1
`define VTA_IRQ_DISARMED 2
`define VTA_IRQ_REFUSED 3
`define VTA_IRQ_SENSE_OFF 4
`endif

// ===== vta_pkg.sv
// Types of the alarm controller
package vta_pkg;
  typedef enum logic [2:0] {
    VTA_IDLE = 3'b000,
    VTA_SIREN = 3'b001,
    VTA_CHECK = 3'b010,
    VTA_ARMED = 3'b011,
    VTA_ALARM = 3'b100
  } vta_state_type;
endpackage

// ===== vta_tick_if.sv
// Seconds time base carrier between timer and controller
interface vta_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ===== vta_tick.sv
// Seconds time base divider
`include "vta_regs.svh"
module vta_tick #(
  parameter int DIV = `VTA_TICK_DIV
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Tick out
  vta_tick_if.src tk
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic pulse;
  logic next_pulse;
  always_comb begin
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (cnt >= 32'(DIV - 1)) begin
      next_cnt = 32'h00000000;
      next_pulse = 1'b1;
    end else begin
      next_cnt = cnt + 32'h00000001;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt <= 32'h00000000;
      pulse <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end
  assign tk.tick = pulse & i_ce;
endmodule

// ===== vta_alarm.sv
// Arming and monitoring controller with Avalon-MM registers
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`include "vta_regs.svh"
module vta_alarm #(
  parameter int TICK_DIV = `VTA_TICK_DIV,
  parameter int DOORS = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // Power states
  input wire logic i_accessory_on,
  input wire logic i_ignition_on,
  // Locking events, taken on the rising edge
  input wire logic i_lock,
  input wire logic i_double_lock,
  input wire logic i_unlock,
  // Contacts, high when closed
  input wire logic [DOORS-1:0] i_door_closed,
  input wire logic i_hood_closed,
  input wire logic i_trunk_closed,
  // Siren tilt unit
  input wire logic i_siren_ready,
  input wire logic i_tilt_plausible,
  input wire logic i_siren_tamper,
  input wire logic i_motion_detect,
  input wire logic i_tilt_detect,
  // Outputs
  output logic o_siren_enable,
  output logic o_tilt_enable,
  output logic o_tilt_init,
  output logic o_motion_active,
  output logic o_contacts_linked,
  output logic o_alarm_audible,
  output logic o_alarm_visual,
  output logic o_led
);
  localparam int NIN = DOORS + 9;
  localparam int CONTACTS = DOORS + 2;
  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] sy1;
  logic [NIN-1:0] sy2;
  assign raw = {i_accessory_on, i_ignition_on, i_lock, i_double_lock, i_unlock,
                i_door_closed, i_hood_closed, i_trunk_closed,
                i_siren_ready, i_siren_tamper};
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sy1 <= '0;
      sy2 <= '0;
    end else if (i_ce) begin
      sy1 <= raw;
      sy2 <= sy1;
    end
  end
  logic [2:0] sy_b1;
  logic [2:0] sy_b2;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sy_b1 <= 3'h0;
      sy_b2 <= 3'h0;
    end else if (i_ce) begin
      sy_b1 <= {i_tilt_plausible, i_motion_detect, i_tilt_detect};
      sy_b2 <= sy_b1;
    end
  end
  logic acc_s, ign_s, lock_s, dlock_s, unlock_s, ready_s, tamper_s;
  logic [CONTACTS-1:0] cont_s;
  assign {acc_s, ign_s, lock_s, dlock_s, unlock_s, cont_s, ready_s, tamper_s} = sy2;
  logic plaus_s, motion_s, tilt_s;
  assign {plaus_s, motion_s, tilt_s} = sy_b2;
  // Edge detect on synchronised event lines
  logic lock_q, dlock_q, unlock_q;
  logic [CONTACTS-1:0] cont_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      lock_q <= 1'b0;
      dlock_q <= 1'b0;
      unlock_q <= 1'b0;
      cont_q <= '0;
    end else if (i_ce) begin
      lock_q <= lock_s;
      dlock_q <= dlock_s;
      unlock_q <= unlock_s;
      cont_q <= cont_s;
    end
  end
  logic lock_ev, dlock_ev, unlock_ev, any_lock;
  logic [CONTACTS-1:0] cont_chg;
  assign lock_ev = lock_s & ~lock_q;
  assign dlock_ev = dlock_s & ~dlock_q;
  assign unlock_ev = unlock_s & ~unlock_q;
  assign any_lock = lock_ev | dlock_ev;
  genvar g;
  for (g = 0; g < CONTACTS; g++) begin : g_chg
    assign cont_chg[g] = cont_s[g] ^ cont_q[g];
  end
  // ----------------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------------
  vta_tick_if tk ();
  vta_tick #(.DIV(TICK_DIV)) u_tick (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .tk(tk)
  );
  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] irq_mask, next_irq_mask;
  logic [4:0] irq_stat, next_irq_stat;
  logic [31:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic [4:0] ev;
  logic enable;
  assign enable = ctrl[`VTA_CTRL_ENABLE];
  // ----------------------------------------------------------------------------
  // Arming state machine
  // ----------------------------------------------------------------------------
  vta_pkg::vta_state_type state, next_state;
  logic [5:0] motion_cnt, next_motion_cnt;
  logic [3:0] relock_cnt, next_relock_cnt;
  logic [1:0] led_cnt, next_led_cnt;
  logic sense_off, next_sense_off;
  logic tilt_on, next_tilt_on;
  logic init, next_init;
  logic motion_on, next_motion_on;
  logic trig;
  assign trig = (|cont_chg) | tamper_s | (tilt_on & tilt_s) | (motion_on & motion_s);
  always_comb begin
    next_state = state;
    next_motion_cnt = motion_cnt;
    next_relock_cnt = relock_cnt;
    next_led_cnt = led_cnt;
    next_sense_off = sense_off;
    next_tilt_on = tilt_on;
    next_init = 1'b0;
    next_motion_on = motion_on;
    ev = 5'h00;
    if (tk.tick && relock_cnt != 4'h0) begin
      next_relock_cnt = relock_cnt - 4'h1;
    end
    if (tk.tick && led_cnt != 2'h0) begin
      next_led_cnt = led_cnt - 2'h1;
    end
    if (unlock_ev && state != vta_pkg::VTA_IDLE) begin
      next_state = vta_pkg::VTA_IDLE;
      next_sense_off = 1'b0;
      next_tilt_on = 1'b0;
      next_motion_on = 1'b0;
      next_relock_cnt = 4'h0;
      ev[`VTA_IRQ_DISARMED] = 1'b1;
    end else begin
      if (dlock_ev && state != vta_pkg::VTA_IDLE) begin
        if (relock_cnt != 4'h0 && !sense_off) begin
          next_sense_off = 1'b1;
          next_tilt_on = 1'b0;
          next_motion_on = 1'b0;
          next_led_cnt = 2'(`VTA_ACK_LED_S);
          ev[`VTA_IRQ_SENSE_OFF] = 1'b1;
        end else if (!sense_off) begin
          next_init = 1'b1;
          next_relock_cnt = 4'(`VTA_RELOCK_WINDOW_S);
        end
      end
      case (state)
        vta_pkg::VTA_IDLE: begin
          if (any_lock && enable && !unlock_ev) begin
            if (acc_s || ign_s) begin
              ev[`VTA_IRQ_REFUSED] = 1'b1;
            end else begin
              next_state = vta_pkg::VTA_SIREN;
              next_init = dlock_ev;
              next_relock_cnt = dlock_ev ? 4'(`VTA_RELOCK_WINDOW_S) : 4'h0;
            end
          end
        end
        vta_pkg::VTA_SIREN: begin
          if (ready_s) begin
            next_state = vta_pkg::VTA_CHECK;
          end
        end
        vta_pkg::VTA_CHECK: begin
          if (&cont_s && cont_chg == '0) begin
            next_state = vta_pkg::VTA_ARMED;
            next_motion_cnt = 6'(`VTA_MOTION_DELAY_S);
            next_tilt_on = plaus_s & ~next_sense_off;
            ev[`VTA_IRQ_ARMED] = 1'b1;
          end
        end
        vta_pkg::VTA_ARMED: begin
          if (tk.tick && motion_cnt != 6'h00) begin
            next_motion_cnt = motion_cnt - 6'h01;
            if (motion_cnt == 6'h01 && !sense_off && !next_sense_off) begin
              next_motion_on = 1'b1;
            end
          end
          if (trig) begin
            next_state = vta_pkg::VTA_ALARM;
            ev[`VTA_IRQ_ALARM] = 1'b1;
          end
        end
        vta_pkg::VTA_ALARM: begin
          next_state = vta_pkg::VTA_ALARM;
        end
        default: begin
          next_state = vta_pkg::VTA_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= vta_pkg::VTA_IDLE;
      motion_cnt <= 6'h00;
      relock_cnt <= 4'h0;
      led_cnt <= 2'h0;
      sense_off <= 1'b0;
      tilt_on <= 1'b0;
      init <= 1'b0;
      motion_on <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      motion_cnt <= next_motion_cnt;
      relock_cnt <= next_relock_cnt;
      led_cnt <= next_led_cnt;
      sense_off <= next_sense_off;
      tilt_on <= next_tilt_on;
      init <= next_init;
      motion_on <= next_motion_on;
    end
  end
  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_siren_enable = (state != vta_pkg::VTA_IDLE);
  assign o_tilt_enable = tilt_on;
  assign o_tilt_init = init;
  assign o_motion_active = motion_on;
  assign o_contacts_linked = (state == vta_pkg::VTA_ARMED) | (state == vta_pkg::VTA_ALARM);
  assign o_alarm_audible = (state == vta_pkg::VTA_ALARM);
  assign o_alarm_visual = (state == vta_pkg::VTA_ALARM);
  logic led_on;
  assign led_on = (led_cnt != 2'h0);
  assign o_led = led_on | o_contacts_linked;
  // ----------------------------------------------------------------------------
  // Avalon-MM slave and interrupts
  // ----------------------------------------------------------------------------
  logic rd_stat;
  assign rd_stat = i_avs_read & ~rvalid & (i_avs_address == `VTA_ADDR_IRQ_STAT);
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_irq_stat = (rd_stat ? 5'h00 : irq_stat) | ev;
    if (i_avs_write) begin
      case (i_avs_address)
        `VTA_ADDR_CTRL: next_ctrl = {31'h0, i_avs_writedata[0]};
        `VTA_ADDR_IRQ_MASK: next_irq_mask = {27'h0, i_avs_writedata[4:0]};
        default: next_ctrl = ctrl;
      endcase
    end
    if (i_avs_read && !rvalid) begin
      next_rvalid = 1'b1;
      case (i_avs_address)
        `VTA_ADDR_CTRL: next_rdata = ctrl;
        `VTA_ADDR_STATUS: next_rdata = {24'h0, sense_off, motion_on, tilt_on, 1'b0, led_on,
                                        state};
        `VTA_ADDR_IRQ_STAT: next_rdata = {27'h0, irq_stat};
        `VTA_ADDR_IRQ_MASK: next_rdata = irq_mask;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl <= `VTA_CTRL_RESET;
      irq_mask <= `VTA_MASK_RESET;
      irq_stat <= 5'h00;
      rdata <= 32'h00000000;
      rvalid <= 1'b0;
    end else if (i_ce) begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end
  assign o_avs_readdata = rdata;
  assign o_avs_waitrequest = (i_avs_read & ~rvalid) | (i_avs_write & ~i_ce);
  assign o_irq = |(irq_stat & irq_mask[4:0]);
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_refuse_power: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ce && state == vta_pkg::VTA_IDLE && (acc_s || ign_s) |=> state == vta_pkg::VTA_IDLE)
    else $error("armed under power");
  a_lock_arms: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ce && state == vta_pkg::VTA_IDLE && any_lock && enable && !acc_s && !ign_s && !unlock_ev
    |=> state == vta_pkg::VTA_SIREN)
    else $error("lock did not arm");
  a_siren_first: assert property (@(posedge i_core_clk) disable iff (i_reset)
    state == vta_pkg::VTA_CHECK |-> o_siren_enable && $past(state) != vta_pkg::VTA_IDLE)
    else $error("check before siren");
  a_link_closed: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ce && state == vta_pkg::VTA_CHECK && !(&cont_s) |=> state != vta_pkg::VTA_ARMED)
    else $error("linked with open contact");
  a_tilt_plaus: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(tilt_on) |-> $past(plaus_s) && !sense_off)
    else $error("tilt without plausible rest");
  a_motion_delay: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(motion_on) |-> $past(state) == vta_pkg::VTA_ARMED && motion_cnt == 6'h00)
    else $error("motion too early");
  a_sense_off: assert property (@(posedge i_core_clk) disable iff (i_reset)
    sense_off |-> !tilt_on && !motion_on)
    else $error("sensing not excluded");
  a_ack_led: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(sense_off) |-> led_cnt == 2'(`VTA_ACK_LED_S) && o_led)
    else $error("no acknowledge led");
  a_alarm_trig: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ce && state == vta_pkg::VTA_ARMED && trig && !unlock_ev
    |=> o_alarm_audible && o_alarm_visual)
    else $error("missed alarm");
  a_unlock_disarm: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_ce && unlock_ev |=> state == vta_pkg::VTA_IDLE && !sense_off)
    else $error("unlock did not disarm");
  c_armed: cover property (@(posedge i_core_clk) state == vta_pkg::VTA_ARMED);
  c_alarm: cover property (@(posedge i_core_clk) state == vta_pkg::VTA_ALARM);
  c_sense_off: cover property (@(posedge i_core_clk) $rose(sense_off));
  c_motion: cover property (@(posedge i_core_clk) $rose(motion_on));
endmodule

// ===== vta_body_model.sv
// Body controller and siren unit model for the alarm controller bench
module vta_body_model (
  // Clock
  input wire logic i_core_clk,
  // Contact and lock status
  output logic [3:0] o_door_closed,
  output logic o_hood_closed,
  output logic o_trunk_closed,
  output logic o_lock,
  output logic o_double_lock,
  output logic o_unlock,
  // Siren tilt unit
  output logic o_siren_ready,
  output logic o_tilt_plausible,
  output logic o_siren_tamper
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_door_closed = 4'hF;
    o_hood_closed = 1'b1;
    o_trunk_closed = 1'b1;
    o_lock = 1'b0;
    o_double_lock = 1'b0;
    o_unlock = 1'b0;
    o_siren_ready = 1'b0;
    o_tilt_plausible = 1'b0;
    o_siren_tamper = 1'b0;
  end
  // Contact change sent at once
  task automatic set_contacts(input logic [3:0] d, input logic h, input logic t);
    @(posedge i_core_clk);
    o_door_closed <= d;
    o_hood_closed <= h;
    o_trunk_closed <= t;
  endtask
  // Siren unit status
  task automatic set_siren(input logic rdy, input logic pl, input logic tmp);
    @(posedge i_core_clk);
    o_siren_ready <= rdy;
    o_tilt_plausible <= pl;
    o_siren_tamper <= tmp;
  endtask
  // Locking event: 0 lock, 1 double lock, 2 unlock
  task automatic pulse(input int kind);
    @(posedge i_core_clk);
    o_lock <= (kind == 0);
    o_double_lock <= (kind == 1);
    o_unlock <= (kind == 2);
    repeat (2) @(posedge i_core_clk);
    o_lock <= 1'b0;
    o_double_lock <= 1'b0;
    o_unlock <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule

// ===== vta_alarm_tb.sv
// Self-checking bench of the alarm controller
module vta_alarm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TDIV = 10;
  logic clk, rst, ce, rd_s, wr_s, acc, ign, mot, tlt;
  logic [3:0] addr;
  logic [31:0] wdat, rdata, r;
  logic waitreq, irq, sir, tilt, init, motion, linked, aud, vis, led;
  logic [3:0] door;
  logic hood, trunk, lk, dlk, ulk, srdy, plaus, tamp;
  logic [7:0] lf;
  int err_count, comparisons, cyc, init_cnt, n, i, k, t0;
  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  vta_body_model body (.i_core_clk(clk), .o_door_closed(door), .o_hood_closed(hood),
    .o_trunk_closed(trunk), .o_lock(lk), .o_double_lock(dlk), .o_unlock(ulk),
    .o_siren_ready(srdy), .o_tilt_plausible(plaus), .o_siren_tamper(tamp));
  vta_alarm #(.TICK_DIV(TDIV), .DOORS(4)) uut (.i_core_clk(clk), .i_reset(rst),
    .i_ce(ce), .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdat), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_irq(irq), .i_accessory_on(acc), .i_ignition_on(ign), .i_lock(lk),
    .i_double_lock(dlk), .i_unlock(ulk), .i_door_closed(door), .i_hood_closed(hood),
    .i_trunk_closed(trunk), .i_siren_ready(srdy), .i_tilt_plausible(plaus),
    .i_siren_tamper(tamp), .i_motion_detect(mot), .i_tilt_detect(tlt),
    .o_siren_enable(sir), .o_tilt_enable(tilt), .o_tilt_init(init),
    .o_motion_active(motion), .o_contacts_linked(linked), .o_alarm_audible(aud),
    .o_alarm_visual(vis), .o_led(led));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (init === 1'b1) init_cnt <= init_cnt + 1;
    if (cyc == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic motion_ok(input int c);
    return (c >= (`VTA_MOTION_DELAY_S - 1) * TDIV) && (c <= (`VTA_MOTION_DELAY_S + 1) * TDIV + 8);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    addr <= a;
    wdat <= wd;
    rd_s <= !wr;
    wr_s <= wr;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  task automatic wait_until(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < lim && (sel == 0 ? linked : sel == 1 ? motion : aud) !== 1'b1);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst, rd_s, wr_s, acc, ign, mot, tlt} = 7'h40;
    ce = 1'b1;
    {addr, wdat, err_count, comparisons, cyc, init_cnt} = '0;
    lf = 8'h16;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk("siren_rst", sir, 32'h0);
    bus(0, `VTA_ADDR_CTRL, 32'h0); chk("ctrl_rst", r, `VTA_CTRL_RESET);
    bus(0, `VTA_ADDR_IRQ_MASK, 32'h0); chk("mask_rst", r, `VTA_MASK_RESET);
    bus(0, 4'h2, 32'h0); chk("unmapped", r, 32'h0);
    for (i = 0; i < 2; i++) begin
      acc <= (i == 0);
      ign <= (i == 1);
      body.pulse(0);
      repeat (6) @(posedge clk);
      chk("refuse", sir, 32'h0);
      bus(0, `VTA_ADDR_IRQ_STAT, 32'h0); chk("refuse_irq", r[`VTA_IRQ_REFUSED], 32'h1);
    end
    acc <= 1'b0;
    ign <= 1'b0;
    bus(1, `VTA_ADDR_IRQ_MASK, 32'h1);
    // Arm on battery feed only, door open at first
    lf = lfsr_next(lf);
    body.set_siren(0, lf[0], 0);
    body.set_contacts(4'hB, 1, 1);
    body.pulse(0);
    repeat (4) @(posedge clk);
    chk("siren_first", sir, 32'h1);
    chk("not_linked", linked, 32'h0);
    bus(0, `VTA_ADDR_STATUS, 32'h0); chk("state_siren", r[2:0], 32'h1);
    body.set_siren(1, lf[0], 0);
    repeat (100) @(posedge clk);
    chk("open_door", linked, 32'h0);
    body.set_contacts(4'hF, 1, 1);
    wait_until(0, 2000);
    t0 = cyc;
    chk("linked", linked, 32'h1);
    chk("tilt_plaus", tilt, lf[0]);
    chk("irq_armed", irq, 32'h1);
    bus(0, `VTA_ADDR_IRQ_STAT, 32'h0); chk("stat_armed", r[`VTA_IRQ_ARMED], 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clear", irq, 32'h0);
    wait_until(1, 400);
    chk("motion_delay", motion_ok(cyc - t0), 32'h1);
    chk("led_armed", led, 32'h1);
    // Clock enable low freezes the contact inputs and the state
    ce <= 1'b0;
    body.set_contacts(4'h7, 1, 1);
    repeat (20) @(posedge clk);
    chk("ce_freeze", aud, 32'h0);
    chk("ce_linked", linked, 32'h1);
    body.set_contacts(4'hF, 1, 1);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ce_resume", aud, 32'h0);
    body.pulse(2);
    repeat (6) @(posedge clk);
    chk("disarm", sir, 32'h0);
    chk("led_off", led, 32'h0);
    // Each trigger source while armed except the motion detector
    for (k = 0; k < 5; k++) begin
      lf = lfsr_next(lf);
      body.set_siren(1, 1, 0);
      body.pulse(k % 2);
      wait_until(0, 2000);
      case (k)
        0: body.set_contacts(~(4'h1 << lf[1:0]), 1, 1);
        1: body.set_contacts(4'hF, 0, 1);
        2: body.set_contacts(4'hF, 1, 0);
        3: body.set_siren(1, 1, 1);
        default: tlt <= 1'b1;
      endcase
      wait_until(2, 20);
      chk("alarm_audible", aud, 32'h1);
      chk("alarm_visual", vis, 32'h1);
      body.pulse(2);
      tlt <= 1'b0;
      body.set_contacts(4'hF, 1, 1);
      repeat (6) @(posedge clk);
      chk("alarm_off", aud, 32'h0);
    end
    // Arm with an implausible rest value
    body.set_siren(1, 0, 0);
    body.pulse(0);
    wait_until(0, 2000);
    chk("tilt_implaus", tilt, 32'h0);
    body.pulse(2);
    body.set_siren(1, 1, 0);
    // Second double lock inside and outside the window
    for (k = 0; k < 2; k++) begin
      i = init_cnt;
      body.pulse(1);
      repeat (4) @(posedge clk);
      chk("init_pulse", init_cnt - i, 32'h1);
      repeat (k == 0 ? 30 : `VTA_RELOCK_WINDOW_S * TDIV + 40) @(posedge clk);
      body.pulse(1);
      repeat (2) @(posedge clk);
      bus(0, `VTA_ADDR_STATUS, 32'h0); chk("ack_led", r[3], k == 0);
      wait_until(0, 2000);
      bus(0, `VTA_ADDR_STATUS, 32'h0); chk("sense_off", r[7], k == 0);
      chk("tilt_off", tilt, k != 0);
      if (k == 0) begin
        repeat (`VTA_MOTION_DELAY_S * TDIV + 40) @(posedge clk);
        chk("motion_off", motion, 32'h0);
        bus(0, `VTA_ADDR_STATUS, 32'h0); chk("ack_led_end", r[3], 32'h0);
        mot <= 1'b1;
        tlt <= 1'b1;
        repeat (10) @(posedge clk);
        chk("no_alarm", aud, 32'h0);
        mot <= 1'b0;
        tlt <= 1'b0;
      end
      body.pulse(2);
    end
    print_verdict();
  end
endmodule
